// File: core/rpm_defs.svh
// constants of the receive-bus upper-bits multiplexer and its host end
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH

// ==========================================================
// link bus layout
`define RPM_BUS_W 12
`define RPM_BIT_MSB10 9
`define RPM_BIT_VIOL 10
`define RPM_BIT_CELL 11
`define RPM_SAR_W 10
`define RPM_BUS_PULL 12'h400

// ==========================================================
// host register offsets (byte addresses)
`define RPM_OFF_CTRL 5'h00
`define RPM_OFF_CMD 5'h04
`define RPM_OFF_SARW 5'h08
`define RPM_OFF_RXWORD 5'h0c
`define RPM_OFF_SARR 5'h10
`define RPM_OFF_STATUS 5'h14
`define RPM_OFF_MASK 5'h18

// ==========================================================
// control register fields
`define RPM_CTRL_CODEC_N 0
`define RPM_CTRL_WIDTH8 1
`define RPM_CTRL_QUEUE_N 2
`define RPM_CTRL_SELFTEST_N 3
`define RPM_CTRL_RX_ACCESS_ENABLE 4
`define RPM_CTRL_RST 5'h0d

// ==========================================================
// command, status and other fields
`define RPM_CMD_GO 0
`define RPM_CMD_READ 1
`define RPM_CMD_BUSY 8
`define RPM_SAR_UNI 10
`define RPM_RX_SC 12
`define RPM_EV_WORD 0
`define RPM_EV_VIOL 1
`define RPM_EV_DONE 2
`define RPM_EV_W 3
`define RPM_UNMAPPED_RD 32'h0000_0000

`endif

// File: core/rpm_pkg.sv
// types shared by both ends of the receive-bus multiplexer
package rpm_pkg;

  // host access sequencer states
  typedef enum logic [1:0] {
    hs_idle,
    hs_pre,
    hs_acc,
    hs_rd
  } rpm_hstate_t;

  // device end state
  typedef struct packed {
    logic [11:0] dout;   // bus bits driven by device
    logic [11:0] doe;    // bus bit enables
    logic sc;            // special flag value
    logic sc_oe;         // special flag enable
    logic [9:0] sar;     // serial address register
    logic unicast;       // matching mode
    logic sar_wr;        // register written pulse
    logic taken;         // word handed out pulse
  } rpm_dev_st_t;

  // host end state
  typedef struct packed {
    logic [4:0] ctrl;
    logic [9:0] sarw;
    logic sarw_uni;
    logic [9:0] sarr;
    logic sarr_uni;
    logic [12:0] rxword;
    logic [2:0] status;
    logic [2:0] mask;
    rpm_hstate_t state;
    logic rd_op;
    logic ack;
    logic [31:0] rdata;
    logic cap;
    logic [11:0] hdo;
    logic [11:0] hoe;
    logic hsc;
    logic hsc_oe;
    logic en;
    logic sel;
  } rpm_host_st_t;

endpackage

// File: core/rpm_if.sv
// link between the device end and the host end
`include "rpm_defs.svh"
interface rpm_if;
  // device drive
  logic [11:0] dev_do;
  logic [11:0] dev_oe;
  logic dev_sc;
  logic dev_sc_oe;
  // host drive
  logic [11:0] host_do;
  logic [11:0] host_oe;
  logic host_sc;
  logic host_sc_oe;
  logic rx_access_enable;
  logic sar_select;
  logic codec_bypass_n;
  logic char_width_select;
  logic queue_bypass_n;
  logic rx_selftest_enable_n;
  // resolved wire levels, undriven bit 10 pulled high
  logic [11:0] receive_word_bus;
  logic rx_special_char_flag;

  assign receive_word_bus = (dev_oe & dev_do) | (host_oe & host_do) |
    (~(dev_oe | host_oe) & `RPM_BUS_PULL);
  assign rx_special_char_flag = (dev_sc_oe & dev_sc) |
    (host_sc_oe & host_sc);

  modport dev (
    input receive_word_bus, rx_special_char_flag, rx_access_enable,
    input sar_select, codec_bypass_n, char_width_select,
    input queue_bypass_n, rx_selftest_enable_n,
    output dev_do, dev_oe, dev_sc, dev_sc_oe
  );

  modport host (
    input receive_word_bus, rx_special_char_flag,
    output host_do, host_oe, host_sc, host_sc_oe, rx_access_enable,
    output sar_select, codec_bypass_n, char_width_select,
    output queue_bypass_n, rx_selftest_enable_n
  );
endinterface

// File: core/rpm_device.sv
// device end: drives received words and owns the serial address register
`include "rpm_defs.svh"
module rpm_device (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // link to host
  rpm_if.dev lnk,
  // decoded receive path
  input wire logic [9:0] i_dec_data,
  input wire logic i_dec_special,
  input wire logic i_code_violation,
  input wire logic [2:0] i_special_code,
  // raw receive path
  input wire logic [11:0] i_raw_char,
  // self-test checker
  input wire logic i_selftest_mismatch,
  // address register view
  output logic [9:0] o_sar_addr,
  output logic o_sar_unicast,
  output logic o_sar_written,
  // word consumed by host
  output logic o_word_taken
);

  // ==========================================================
  // state
  rpm_pkg::rpm_dev_st_t st_ff; // all device state
  rpm_pkg::rpm_dev_st_t nxt_st; // next state

  // ==========================================================
  // word mapping
  // builds bus bits and the special flag for a data access;
  // returns {sc_oe, sc, bus[11:0]}
  function automatic logic [13:0] rpm_map(
    input logic codec_n,
    input logic width8,
    input logic queue_n,
    input logic selftest_n,
    input logic [9:0] dec,
    input logic dec_sc,
    input logic viol,
    input logic [2:0] code,
    input logic [11:0] raw,
    input logic mism
  );
    logic [11:0] w;
    logic sc;
    logic sc_oe;
    w = 12'h000;
    sc = 1'b0;
    sc_oe = 1'b0;
    if (codec_n) begin
      // decoded character on the low bits
      w[9:0] = dec;
      // eight-bit mode leaves bit 9 without meaning; drive it low
      if (width8) begin
        w[`RPM_BIT_MSB10] = 1'b0;
      end else begin
        w[`RPM_BIT_MSB10] = dec[9];
      end
      sc_oe = 1'b1;
      if (queue_n) begin
        // three flags carry the special character code
        w[`RPM_BIT_VIOL] = code[2];
        w[`RPM_BIT_CELL] = code[1];
        sc = code[0];
      end else begin
        // direct path: violation and special marker
        w[`RPM_BIT_VIOL] = viol;
        w[`RPM_BIT_CELL] = 1'b0;
        sc = dec_sc;
      end
    end else begin
      // raw character, low ten bits always present
      w[7:0] = raw[7:0];
      w[8] = raw[8];
      w[`RPM_BIT_MSB10] = raw[9];
      if (width8) begin
        w[`RPM_BIT_VIOL] = 1'b0;
        w[`RPM_BIT_CELL] = 1'b0;
      end else begin
        w[`RPM_BIT_VIOL] = raw[10];
        w[`RPM_BIT_CELL] = raw[11];
      end
      // special flag left undriven in raw mode
      sc_oe = 1'b0;
    end
    // self-test reuses the violation line for mismatches
    if (!selftest_n) begin
      w[`RPM_BIT_VIOL] = mism;
    end
    return {sc_oe, sc, w};
  endfunction

  // ==========================================================
  // next-state logic
  // decides once per edge whether the host reads data, writes
  // or reads the address register, or leaves the bus alone
  always_comb begin
    logic [13:0] m;
    m = rpm_map(lnk.codec_bypass_n, lnk.char_width_select,
      lnk.queue_bypass_n, lnk.rx_selftest_enable_n, i_dec_data,
      i_dec_special, i_code_violation, i_special_code, i_raw_char,
      i_selftest_mismatch);
    nxt_st = st_ff;
    // pulses and enables fall back by default
    nxt_st.sar_wr = 1'b0;
    nxt_st.taken = 1'b0;
    nxt_st.doe = 12'h000;
    nxt_st.sc_oe = 1'b0;
    // nothing moves without the access enable
    if (lnk.rx_access_enable) begin
      if (lnk.sar_select) begin
        if (!lnk.receive_word_bus[`RPM_BIT_VIOL]) begin
          // write: host drives bits 9:0 and the special flag
          nxt_st.sar = lnk.receive_word_bus[9:0];
          nxt_st.unicast = lnk.rx_special_char_flag;
          nxt_st.sar_wr = 1'b1;
        end else begin
          // read: device drives bits 9:0 and the special flag,
          // bit 10 stays with the host as direction input
          nxt_st.dout[9:0] = st_ff.sar;
          nxt_st.doe[9:0] = 10'h3ff;
          nxt_st.sc = st_ff.unicast;
          nxt_st.sc_oe = 1'b1;
        end
      end else begin
        // data access: whole bus driven from the mapped word
        nxt_st.dout = m[11:0];
        nxt_st.doe = 12'hfff;
        nxt_st.sc = m[12];
        nxt_st.sc_oe = m[13];
        nxt_st.taken = 1'b1;
      end
    end
  end

  // ==========================================================
  // state register
  // every bus output and every sample moves on the rising edge
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  // link drive comes straight from the state register
  assign lnk.dev_do = st_ff.dout;
  assign lnk.dev_oe = st_ff.doe;
  assign lnk.dev_sc = st_ff.sc;
  assign lnk.dev_sc_oe = st_ff.sc_oe;
  // register view for the address matcher
  assign o_sar_addr = st_ff.sar;
  assign o_sar_unicast = st_ff.unicast;
  assign o_sar_written = st_ff.sar_wr;
  // tells the receive path that the host took a word
  assign o_word_taken = st_ff.taken;

endmodule

// File: core/rpm_host.sv
// host end: reads received words and accesses the address register
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`include "rpm_defs.svh"
module rpm_host (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // link to device
  rpm_if.host lnk,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // interrupt
  output logic o_irq
);

  // ==========================================================
  // state
  rpm_pkg::rpm_host_st_t st_ff; // all host state
  rpm_pkg::rpm_host_st_t nxt_st; // next state

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [2:0] ev; // events this cycle
    logic [2:0] clr; // write-one clear
    logic go; // access command accepted
    logic [12:0] w; // captured word
    ev = 3'h0;
    clr = 3'h0;
    go = 1'b0;
    w = {lnk.rx_special_char_flag, lnk.receive_word_bus};
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    // bus slave: one wait cycle, then answer
    if ((i_avs_read || i_avs_write) && !st_ff.ack) begin
      nxt_st.ack = 1'b1;
      if (i_avs_write) begin
        unique case (i_avs_address)
          `RPM_OFF_CTRL: nxt_st.ctrl = i_avs_writedata[4:0];
          `RPM_OFF_CMD: begin
            go = i_avs_writedata[`RPM_CMD_GO] &&
              st_ff.state == rpm_pkg::hs_idle;
            if (go) begin
              nxt_st.rd_op = i_avs_writedata[`RPM_CMD_READ];
            end
          end
          `RPM_OFF_SARW: begin
            nxt_st.sarw = i_avs_writedata[9:0];
            nxt_st.sarw_uni = i_avs_writedata[`RPM_SAR_UNI];
          end
          `RPM_OFF_STATUS: clr = i_avs_writedata[2:0];
          `RPM_OFF_MASK: nxt_st.mask = i_avs_writedata[2:0];
          default: ;
        endcase
      end else begin
        unique case (i_avs_address)
          `RPM_OFF_CTRL: nxt_st.rdata = {27'h0, st_ff.ctrl};
          `RPM_OFF_CMD: nxt_st.rdata =
            {23'h0, st_ff.state != rpm_pkg::hs_idle, 8'h0};
          `RPM_OFF_SARW: nxt_st.rdata =
            {21'h0, st_ff.sarw_uni, st_ff.sarw};
          `RPM_OFF_RXWORD: nxt_st.rdata = {19'h0, st_ff.rxword};
          `RPM_OFF_SARR: nxt_st.rdata =
            {21'h0, st_ff.sarr_uni, st_ff.sarr};
          `RPM_OFF_STATUS: nxt_st.rdata = {29'h0, st_ff.status};
          `RPM_OFF_MASK: nxt_st.rdata = {29'h0, st_ff.mask};
          default: nxt_st.rdata = `RPM_UNMAPPED_RD;
        endcase
      end
    end
    // word capture one edge after the device took the enable
    nxt_st.cap = st_ff.en && !st_ff.sel;
    if (st_ff.cap) begin
      // bit 9 is meaningless in coded eight-bit mode
      if (st_ff.ctrl[`RPM_CTRL_CODEC_N] &&
          st_ff.ctrl[`RPM_CTRL_WIDTH8]) begin
        w[`RPM_BIT_MSB10] = 1'b0;
      end
      nxt_st.rxword = w;
      ev[`RPM_EV_WORD] = 1'b1;
      ev[`RPM_EV_VIOL] = w[`RPM_BIT_VIOL] &&
        ((st_ff.ctrl[`RPM_CTRL_CODEC_N] &&
        !st_ff.ctrl[`RPM_CTRL_QUEUE_N]) ||
        !st_ff.ctrl[`RPM_CTRL_SELFTEST_N]);
    end
    // access sequencer
    nxt_st.hoe = 12'h000;
    nxt_st.hsc_oe = 1'b0;
    nxt_st.sel = 1'b0;
    unique case (st_ff.state)
      rpm_pkg::hs_idle: begin
        nxt_st.en = st_ff.ctrl[`RPM_CTRL_RX_ACCESS_ENABLE];
        if (go) begin
          // drop enable first so the device leaves the bus
          nxt_st.en = 1'b0;
          nxt_st.state = rpm_pkg::hs_pre;
        end
      end
      rpm_pkg::hs_pre: begin
        nxt_st.en = 1'b1;
        nxt_st.sel = 1'b1;
        nxt_st.hoe[`RPM_BIT_VIOL] = 1'b1;
        nxt_st.hdo[`RPM_BIT_VIOL] = st_ff.rd_op;
        if (!st_ff.rd_op) begin
          nxt_st.hoe[9:0] = 10'h3ff;
          nxt_st.hdo[9:0] = st_ff.sarw;
          nxt_st.hsc = st_ff.sarw_uni;
          nxt_st.hsc_oe = 1'b1;
        end
        nxt_st.state = rpm_pkg::hs_acc;
      end
      rpm_pkg::hs_acc: begin
        nxt_st.en = 1'b0;
        if (st_ff.rd_op) begin
          nxt_st.state = rpm_pkg::hs_rd;
        end else begin
          ev[`RPM_EV_DONE] = 1'b1;
          nxt_st.state = rpm_pkg::hs_idle;
        end
      end
      rpm_pkg::hs_rd: begin
        // device drives the register during this cycle
        nxt_st.sarr = lnk.receive_word_bus[9:0];
        nxt_st.sarr_uni = lnk.rx_special_char_flag;
        ev[`RPM_EV_DONE] = 1'b1;
        nxt_st.state = rpm_pkg::hs_idle;
      end
    endcase
    // sticky flags: a new event beats a clear
    nxt_st.status = (st_ff.status & ~clr) | ev;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
      st_ff.ctrl <= `RPM_CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign lnk.host_do = st_ff.hdo;
  assign lnk.host_oe = st_ff.hoe;
  assign lnk.host_sc = st_ff.hsc;
  assign lnk.host_sc_oe = st_ff.hsc_oe;
  assign lnk.rx_access_enable = st_ff.en;
  assign lnk.sar_select = st_ff.sel;
  assign lnk.codec_bypass_n = st_ff.ctrl[`RPM_CTRL_CODEC_N];
  assign lnk.char_width_select = st_ff.ctrl[`RPM_CTRL_WIDTH8];
  assign lnk.queue_bypass_n = st_ff.ctrl[`RPM_CTRL_QUEUE_N];
  assign lnk.rx_selftest_enable_n = st_ff.ctrl[`RPM_CTRL_SELFTEST_N];
  assign o_avs_readdata = st_ff.rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_ff.ack;
  assign o_irq = |(st_ff.status & st_ff.mask);

endmodule

// File: verification/rpm_asserts.sv
// checker of the link between the device end and the host end
module rpm_asserts (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // device drive
  input wire logic [11:0] dev_do,
  input wire logic [11:0] dev_oe,
  input wire logic dev_sc,
  input wire logic dev_sc_oe,
  // host drive
  input wire logic [11:0] host_oe,
  input wire logic host_sc_oe,
  input wire logic rx_access_enable,
  input wire logic sar_select,
  input wire logic codec_bypass_n,
  input wire logic char_width_select,
  input wire logic rx_selftest_enable_n,
  // resolved wires
  input wire logic [11:0] receive_word_bus,
  input wire logic rx_special_char_flag
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ==========================================================
  // helper: last register word written over the link
  logic wr_acc; // register write edge
  logic rd_acc; // register read edge
  logic [10:0] sar_ff; // {unicast, address}
  logic seen_ff; // a write has happened
  assign wr_acc = rx_access_enable & sar_select & ~receive_word_bus[10];
  assign rd_acc = rx_access_enable & sar_select & receive_word_bus[10];

  // capture what the host wrote, to compare a later read against
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sar_ff <= 11'h000;
      seen_ff <= 1'b0;
    end else if (wr_acc) begin
      sar_ff <= {rx_special_char_flag, receive_word_bus[9:0]};
      seen_ff <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  drive_needs_en_a: assert property (
    (dev_oe != 12'h000 || dev_sc_oe) |-> $past(rx_access_enable))
    else $error("device drives link without enable");
  data_drive_a: assert property (
    rx_access_enable && !sar_select |=> dev_oe == 12'hfff)
    else $error("data access not driven next cycle");
  raw_bit11_low_a: assert property (
    $past(!codec_bypass_n && char_width_select) && dev_oe[11]
    |-> !dev_do[11])
    else $error("bit 11 not low in raw eight-bit mode");
  raw_bit10_low_a: assert property (
    $past(!codec_bypass_n && char_width_select && rx_selftest_enable_n)
    && dev_oe[10] |-> !dev_do[10])
    else $error("bit 10 not low in raw eight-bit mode");
  raw_sc_idle_a: assert property (
    $past(rx_access_enable && !sar_select && !codec_bypass_n)
    |-> !dev_sc_oe)
    else $error("special flag driven in raw mode");
  sar_write_hiz_a: assert property (
    wr_acc |=> dev_oe[9:0] == 10'h000 && !dev_sc_oe)
    else $error("device drives during register write");
  sar_read_drive_a: assert property (
    rd_acc |=> dev_oe[9:0] == 10'h3ff && dev_sc_oe)
    else $error("device silent during register read");
  sar_readback_a: assert property (
    rd_acc && seen_ff |=> dev_do[9:0] == sar_ff[9:0]
    && dev_sc == sar_ff[10])
    else $error("register read differs from last write");
  bus_no_clash_a: assert property (
    (dev_oe & host_oe) == 12'h000 && !(dev_sc_oe && host_sc_oe))
    else $error("both ends drive the same line");

  // ==========================================================
  // covers of the main scenarios
  cover property (wr_acc);
  cover property (rd_acc ##1 dev_sc_oe);
  cover property (rx_access_enable && !sar_select && !codec_bypass_n);
endmodule

// File: verification/rpm_tb.sv
// self-checking bench joining the device end and the host end
`include "rpm_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // clock, reset and device stimulus
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [9:0] dec_data = 10'h2a5; // decoded char, bit 9 set
  logic dec_special = 1'b1; // special marker
  logic code_viol = 1'b1; // bad code word
  logic [2:0] special_code = 3'b010; // cell flag only
  logic [11:0] raw_char = 12'hea5; // raw char, top bits set
  logic mismatch = 1'b0; // self-test mismatch
  // avalon master and observed outputs
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [9:0] sar_addr;
  logic sar_uni;
  logic [31:0] rd; // last read data
  int bad_count = 0;
  int samples_checked = 0;
  // control word and expected word per strap mode
  logic [4:0] ctrl_tab [6] = '{5'h1d, 5'h1f, 5'h19, 5'h1c, 5'h1e, 5'h16};
  logic [12:0] exp_tab [6] = '{13'h0aa5, 13'h08a5, 13'h16a5, 13'h0ea5,
    13'h02a5, 13'h06a5};
  logic [10:0] sar_tab [2] = '{11'h6d3, 11'h11a}; // unicast, multicast

  always #25 i_ref_clk = ~i_ref_clk;

  // ==========================================================
  // both ends and the checker
  rpm_if lnk_if ();
  rpm_device rpm_device_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .lnk(lnk_if.dev), .i_dec_data(dec_data), .i_dec_special(dec_special),
    .i_code_violation(code_viol), .i_special_code(special_code),
    .i_raw_char(raw_char), .i_selftest_mismatch(mismatch),
    .o_sar_addr(sar_addr), .o_sar_unicast(sar_uni), .o_sar_written(),
    .o_word_taken());
  rpm_host rpm_host_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .lnk(lnk_if.host), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .o_irq(irq));
  rpm_asserts rpm_asserts_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .dev_do(lnk_if.dev_do), .dev_oe(lnk_if.dev_oe),
    .dev_sc(lnk_if.dev_sc), .dev_sc_oe(lnk_if.dev_sc_oe),
    .host_oe(lnk_if.host_oe), .host_sc_oe(lnk_if.host_sc_oe),
    .rx_access_enable(lnk_if.rx_access_enable),
    .sar_select(lnk_if.sar_select),
    .codec_bypass_n(lnk_if.codec_bypass_n),
    .char_width_select(lnk_if.char_width_select),
    .rx_selftest_enable_n(lnk_if.rx_selftest_enable_n),
    .receive_word_bus(lnk_if.receive_word_bus),
    .rx_special_char_flag(lnk_if.rx_special_char_flag));

  // ==========================================================
  // tasks
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic av_xfer(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    logic seen; // waitrequest seen low before the closing edge
    n = 0;
    seen = 1'b0;
    @(posedge i_ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    // look at waitrequest mid-cycle, away from the launching edge
    do begin
      @(negedge i_ref_clk);
      n++;
      seen = (avs_waitrequest === 1'b0);
    end while (!seen && n < 50);
    // the transfer completes at the next rising edge
    @(posedge i_ref_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // a slave that never answers ends the run
    if (!seen) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // read status until an event bit is set, bounded
  task automatic poll(input int b);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[b] !== 1'b1 && n < 60) begin
      av_xfer(1'b0, `RPM_OFF_STATUS, 32'h0);
      n++;
    end
    chk((rd >> b) & 32'h1, 32'h1);
  endtask

  // counts and verdict, the single end of the run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    av_xfer(1'b0, `RPM_OFF_CTRL, 32'h0);
    chk(rd, {27'h0, `RPM_CTRL_RST});
    chk({31'h0, irq}, 32'h0);
    $display("reset test done");
    // six strap modes: straps set with enable off, then enable on, last captured word read after enable drops
    for (int m = 0; m < 6; m++) begin
      mismatch <= (m == 5);
      av_xfer(1'b1, `RPM_OFF_CTRL, {27'h0, ctrl_tab[m] & 5'h0f});
      av_xfer(1'b1, `RPM_OFF_STATUS, 32'h7);
      av_xfer(1'b1, `RPM_OFF_CTRL, {27'h0, ctrl_tab[m]});
      poll(`RPM_EV_WORD);
      av_xfer(1'b1, `RPM_OFF_CTRL, {27'h0, ctrl_tab[m] & 5'h0f});
      av_xfer(1'b0, `RPM_OFF_RXWORD, 32'h0);
      chk(rd, {19'h0, exp_tab[m]});
      // the compare above also
      $display("mode %0d test done", m);
    end
    // address register written then read back, both matching modes
    av_xfer(1'b1, `RPM_OFF_CTRL, 32'h0d);
    for (int i = 0; i < 2; i++) begin
      av_xfer(1'b1, `RPM_OFF_SARW, {21'h0, sar_tab[i]});
      av_xfer(1'b1, `RPM_OFF_STATUS, 32'h7);
      av_xfer(1'b1, `RPM_OFF_CMD, 32'h1);
      poll(`RPM_EV_DONE);
      chk({21'h0, sar_uni, sar_addr}, {21'h0, sar_tab[i]});
      av_xfer(1'b1, `RPM_OFF_STATUS, 32'h7);
      av_xfer(1'b1, `RPM_OFF_CMD, 32'h3);
      poll(`RPM_EV_DONE);
      av_xfer(1'b0, `RPM_OFF_SARR, 32'h0);
      chk(rd, {21'h0, sar_tab[i]});
      $display("register access %0d test done", i);
    end
    // interrupt: masked, unmasked, cleared
    av_xfer(1'b1, `RPM_OFF_CTRL, 32'h1d);
    poll(`RPM_EV_WORD);
    av_xfer(1'b1, `RPM_OFF_CTRL, 32'h0d);
    chk({31'h0, irq}, 32'h0);
    av_xfer(1'b1, `RPM_OFF_MASK, 32'h1);
    @(negedge i_ref_clk);
    chk({31'h0, irq}, 32'h1);
    av_xfer(1'b1, `RPM_OFF_STATUS, 32'h1);
    @(negedge i_ref_clk);
    chk({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    // unmapped place: write ignored, read gives zero
    av_xfer(1'b1, 5'h1c, 32'hffff_ffff);
    av_xfer(1'b0, 5'h1c, 32'h0);
    chk(rd, `RPM_UNMAPPED_RD);
    av_xfer(1'b0, `RPM_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_000d);
    $display("unmapped test done");
    tally_and_finish();
  end
endmodule
